/* src/bmss_pkg.sv */
package bmss_pkg;

    // Boot modes
    typedef enum logic [1:0] {
        BMSS_MODE_USER_LOADER,
        BMSS_MODE_DEBUG,
        BMSS_MODE_RESERVED
    } bmss_mode_e;

    // Reset classes presented by the reset controller
    typedef enum logic [1:0] {
        BMSS_RST_COLD,
        BMSS_RST_WARM,
        BMSS_RST_HOT,
        BMSS_RST_NONE
    } bmss_rst_e;

    // Nonvolatile memory layout
    localparam logic [31:0] BMSS_ADDR_STARTUP    = 32'h0000_0000;
    localparam logic [31:0] BMSS_ADDR_USER_NVM   = 32'h1100_0000;
    localparam logic [31:0] BMSS_ADDR_RESET_VEC  = 32'h1100_0004;
    localparam logic [31:0] BMSS_VEC_ERASED      = 32'hffff_ffff;

    // No-activity count encodings
    localparam logic [7:0]  BMSS_NAC_ZERO        = 8'h00;
    localparam logic [7:0]  BMSS_NAC_MIN         = 8'h02;
    localparam logic [7:0]  BMSS_NAC_MAX         = 8'h1c;
    localparam logic [7:0]  BMSS_NAC_FOREVER     = 8'hff;

    // NAC granularity: 5 ms per count
    localparam int          BMSS_CLK_MHZ         = 100;
    localparam int          BMSS_NAC_STEP_US     = 5000;
    localparam int          BMSS_NAC_STEP_CYC    = BMSS_NAC_STEP_US * BMSS_CLK_MHZ;
    localparam int          BMSS_STEP_W          = 20;

    // Configuration read from the configuration sector
    typedef struct packed {
        logic        ram_mode_full;
        logic        data_linear;
        logic [7:0]  nac;
        logic        nac_ecc_err;
        logic [15:0] trim;
    } bmss_cfg_s;

    // One-cycle step request to the init engines, one bit per step
    typedef struct packed {
        logic wdt_off;
        logic ram_test;
        logic ram_clear;
        logic map_init;
        logic trim_load;
        logic pll_switch;
    } bmss_step_s;

endpackage

/* src/bmss_mode_latch.sv */
`timescale 1ns/1ps
`default_nettype none
module bmss_mode_latch
    import bmss_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Pins
    input  wire logic       mode_data_pin,
    input  wire logic       mode_clock_pin,
    // Result
    output bmss_mode_e      mode,
    output logic            mode_valid
);

    logic       taken_r;
    logic       taken_nxt;
    bmss_mode_e mode_r;
    bmss_mode_e mode_nxt;

    // Caught on the first edge after reset release, then frozen
    always_comb begin
        taken_nxt = 1'b1;
        mode_nxt  = mode_r;
        if (!taken_r) begin
            if (!mode_data_pin) begin
                mode_nxt = BMSS_MODE_USER_LOADER;
            end else if (mode_clock_pin) begin
                mode_nxt = BMSS_MODE_DEBUG;
            end else begin
                mode_nxt = BMSS_MODE_RESERVED;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            taken_r <= 1'b0;
            mode_r  <= BMSS_MODE_USER_LOADER;
        end else begin
            taken_r <= taken_nxt;
            mode_r  <= mode_nxt;
        end
    end

    assign mode       = mode_r;
    assign mode_valid = taken_r;

    a_mode_frozen: assert property (@(posedge clk) disable iff (!rstn)
        taken_r |=> mode_r == $past(mode_r))
        else $error("boot mode changed after capture");

endmodule
`default_nettype wire

/* src/bmss_nac_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module bmss_nac_timer
    import bmss_pkg::*;
#(
    parameter int STEP_CYC = BMSS_NAC_STEP_CYC
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Control
    input  wire logic       start,
    input  wire logic       stop,
    input  wire logic [7:0] count,
    // Status
    output logic            expired
);

    logic [BMSS_STEP_W-1:0] step_r;
    logic [BMSS_STEP_W-1:0] step_nxt;
    logic [7:0]             left_r;
    logic [7:0]             left_nxt;
    logic                   run_r;
    logic                   run_nxt;
    logic                   exp_r;
    logic                   exp_nxt;

    always_comb begin
        step_nxt = step_r;
        left_nxt = left_r;
        run_nxt  = run_r;
        exp_nxt  = exp_r;
        if (start) begin
            step_nxt = '0;
            left_nxt = count;
            run_nxt  = (count != BMSS_NAC_ZERO);
            exp_nxt  = (count == BMSS_NAC_ZERO);
        end else if (stop) begin
            run_nxt = 1'b0;
        end else if (run_r) begin
            if (step_r == BMSS_STEP_W'(STEP_CYC - 1)) begin
                step_nxt = '0;
                left_nxt = left_r - 8'h01;
                if (left_r == 8'h01) begin
                    run_nxt = 1'b0;
                    exp_nxt = 1'b1;
                end
            end else begin
                step_nxt = step_r + BMSS_STEP_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            step_r <= '0;
            left_r <= 8'h00;
            run_r  <= 1'b0;
            exp_r  <= 1'b0;
        end else begin
            step_r <= step_nxt;
            left_r <= left_nxt;
            run_r  <= run_nxt;
            exp_r  <= exp_nxt;
        end
    end

    assign expired = exp_r;

endmodule
`default_nettype wire

/* src/bmss_top.sv */
// Operation
// - Boot-mode pins are caught at reset release and pick the mode.
// - Data pin low gives user/loader; both high give debug; rest reserved.
// - An erased reset vector sends the device to sleep.
// - User/loader mode without a finished download enters user only with a programmed vector and a valid no-activity count.
// - An invalid no-activity count waits for the loader with no timeout.
// - User entry sets vector table to user memory and branches to vector.
// - Reset type is checked first, before any initialization step.
// - Steps depend on boot mode; hot reset skips some.
// - RAM self-test, then RAM clear, range set by RAM mode.
// - Map-RAM init with repair only in linear data mode.
// - Load analog trimming, then switch system clock to PLL.
// - After clock setup start the no-activity timer.
// - Debug mode finishes init, waits for debugger sync, then starts user code.
// - User and debug entry leave identical RAM and register state, watchdog aside.
// - Debug mode keeps the primary watchdog off except in the error loop.
// - Startup runs from address zero after every reset.
// - Step parameters come from the configuration sector.
// - No-activity count zero enters user mode at once.
`timescale 1ns/1ps
`default_nettype none
module bmss_top
    import bmss_pkg::*;
#(
    parameter int NAC_STEP_CYC = BMSS_NAC_STEP_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Boot-mode pins
    input  wire logic        mode_data_pin,
    input  wire logic        mode_clock_pin,
    // Reset class and configuration sector
    input  wire bmss_rst_e   rst_type,
    input  wire logic        cfg_valid,
    input  wire bmss_cfg_s   cfg,
    input  wire logic [31:0] reset_vec,
    input  wire logic        init_fail,
    // Init engines
    output bmss_step_s       step_go,
    input  wire logic        step_done,
    output logic             ram_full_range,
    output logic [15:0]      trim_val,
    // Loader link and debugger
    input  wire logic        loader_active,
    input  wire logic        loader_done,
    input  wire logic        dbg_synced,
    // Results
    output logic             primary_watchdog_en,
    output logic [31:0]      fetch_addr,
    output logic [31:0]      vtor,
    output logic [31:0]      branch_addr,
    output logic             user_start,
    output logic             sleep_req,
    output logic             error_loop,
    output logic             loader_wait
);

    typedef enum logic [3:0] {
        S_RTYPE, S_MODE, S_WDT, S_RAMT, S_RAMC, S_MAP, S_TRIM, S_PLL,
        S_NAC, S_LOADER, S_DBG, S_USER, S_SLEEP, S_ERR
    } bmss_state_e;

    bmss_mode_e  mode;
    logic        mode_valid;
    logic        nac_expired;

    bmss_state_e st_r, st_nxt;
    logic        hot_r, hot_nxt;
    bmss_step_s  go_r, go_nxt;
    logic        busy_r, busy_nxt;
    logic        wdt_r, wdt_nxt;
    logic [31:0] fetch_r, fetch_nxt;
    logic [31:0] vtor_r, vtor_nxt;
    logic [31:0] br_r, br_nxt;
    logic        user_r, user_nxt;
    logic        sleep_r, sleep_nxt;
    logic        err_r, err_nxt;
    logic        lw_r, lw_nxt;
    logic        ramf_r, ramf_nxt;
    logic [15:0] trim_r, trim_nxt;
    logic        nac_start;
    logic        nac_ok;
    logic        vec_ok;

    bmss_mode_latch u_mode (
        .clk            (clk),
        .rstn           (rstn),
        .mode_data_pin  (mode_data_pin),
        .mode_clock_pin (mode_clock_pin),
        .mode           (mode),
        .mode_valid     (mode_valid)
    );

    bmss_nac_timer #(
        .STEP_CYC (NAC_STEP_CYC)
    ) u_nac (
        .clk     (clk),
        .rstn    (rstn),
        .start   (nac_start),
        .stop    (loader_active),
        .count   (cfg.nac),
        .expired (nac_expired)
    );

    // Valid NAC: no ECC error, and zero or within the timed range
    assign nac_ok = !cfg.nac_ecc_err &&
                    ((cfg.nac == BMSS_NAC_ZERO) ||
                     (cfg.nac >= BMSS_NAC_MIN && cfg.nac <= BMSS_NAC_MAX));
    assign vec_ok = (reset_vec != BMSS_VEC_ERASED);
    assign nac_start = (st_r == S_PLL) && busy_r && step_done;

    always_comb begin
        st_nxt    = st_r;
        hot_nxt   = hot_r;
        go_nxt    = '0;
        busy_nxt  = busy_r;
        wdt_nxt   = wdt_r;
        fetch_nxt = fetch_r;
        vtor_nxt  = vtor_r;
        br_nxt    = br_r;
        user_nxt  = 1'b0;
        sleep_nxt = sleep_r;
        err_nxt   = err_r;
        lw_nxt    = lw_r;
        ramf_nxt  = ramf_r;
        trim_nxt  = trim_r;
        unique case (st_r)
            S_RTYPE: begin
                // Reset class first, nothing else yet
                if (rst_type != BMSS_RST_NONE) begin
                    hot_nxt = (rst_type == BMSS_RST_HOT);
                    st_nxt  = S_MODE;
                end
            end
            S_MODE: begin
                // Waits for pins and configuration sector
                if (mode_valid && cfg_valid) begin
                    fetch_nxt = BMSS_ADDR_RESET_VEC;
                    ramf_nxt  = cfg.ram_mode_full;
                    trim_nxt  = cfg.trim;
                    if (mode == BMSS_MODE_RESERVED) begin
                        st_nxt = S_ERR;
                    end else begin
                        st_nxt = S_WDT;
                    end
                end
            end
            S_WDT: begin
                // Debug keeps watchdog off so a stalled core is not reset
                if (mode == BMSS_MODE_DEBUG) begin
                    wdt_nxt           = 1'b0;
                    go_nxt.wdt_off    = 1'b1;
                end
                st_nxt = hot_r ? S_TRIM : S_RAMT;
            end
            S_RAMT, S_RAMC, S_MAP, S_TRIM, S_PLL: begin
                if (!busy_r) begin
                    busy_nxt = 1'b1;
                    unique case (st_r)
                        S_RAMT: go_nxt.ram_test  = 1'b1;
                        S_RAMC: go_nxt.ram_clear = 1'b1;
                        S_MAP:  go_nxt.map_init  = 1'b1;
                        S_TRIM: go_nxt.trim_load = 1'b1;
                        default: go_nxt.pll_switch = !hot_r;
                    endcase
                end else if (init_fail) begin
                    busy_nxt = 1'b0;
                    st_nxt   = S_ERR;
                end else if (step_done) begin
                    busy_nxt = 1'b0;
                    // Fixed order of steps
                    unique case (st_r)
                        S_RAMT: st_nxt = S_RAMC;
                        S_RAMC: st_nxt = cfg.data_linear ? S_MAP : S_TRIM;
                        S_MAP:  st_nxt = S_TRIM;
                        S_TRIM: st_nxt = S_PLL;
                        default: st_nxt = S_NAC;
                    endcase
                end
            end
            S_NAC: begin
                if (mode == BMSS_MODE_DEBUG) begin
                    st_nxt = S_DBG;
                end else if (!vec_ok) begin
                    sleep_nxt = 1'b1;
                    st_nxt    = S_SLEEP;
                end else if (!nac_ok) begin
                    lw_nxt  = 1'b1;
                    st_nxt  = S_LOADER;
                end else if (cfg.nac == BMSS_NAC_ZERO) begin
                    st_nxt = S_USER;
                end else begin
                    lw_nxt = 1'b1;
                    st_nxt = S_LOADER;
                end
            end
            S_LOADER: begin
                // Invalid count never times out
                if (loader_done && vec_ok) begin
                    lw_nxt = 1'b0;
                    st_nxt = S_USER;
                end else if (nac_ok && nac_expired && !loader_active) begin
                    lw_nxt = 1'b0;
                    st_nxt = S_USER;
                end
            end
            S_DBG: begin
                if (dbg_synced) begin
                    st_nxt = vec_ok ? S_USER : S_SLEEP;
                    sleep_nxt = !vec_ok;
                end
            end
            S_USER: begin
                // Same entry path for both modes keeps state identical
                if (!user_r && vtor_r != BMSS_ADDR_USER_NVM) begin
                    vtor_nxt = BMSS_ADDR_USER_NVM;
                    br_nxt   = reset_vec;
                    user_nxt = 1'b1;
                end
            end
            S_SLEEP: begin
                sleep_nxt = 1'b1;
            end
            S_ERR: begin
                err_nxt = 1'b1;
                wdt_nxt = 1'b1;
            end
            default: begin
                st_nxt = S_ERR;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r    <= S_RTYPE;
            hot_r   <= 1'b0;
            go_r    <= '0;
            busy_r  <= 1'b0;
            wdt_r   <= 1'b1;
            fetch_r <= BMSS_ADDR_STARTUP;
            vtor_r  <= BMSS_ADDR_STARTUP;
            br_r    <= BMSS_ADDR_STARTUP;
            user_r  <= 1'b0;
            sleep_r <= 1'b0;
            err_r   <= 1'b0;
            lw_r    <= 1'b0;
            ramf_r  <= 1'b0;
            trim_r  <= 16'h0000;
        end else begin
            st_r    <= st_nxt;
            hot_r   <= hot_nxt;
            go_r    <= go_nxt;
            busy_r  <= busy_nxt;
            wdt_r   <= wdt_nxt;
            fetch_r <= fetch_nxt;
            vtor_r  <= vtor_nxt;
            br_r    <= br_nxt;
            user_r  <= user_nxt;
            sleep_r <= sleep_nxt;
            err_r   <= err_nxt;
            lw_r    <= lw_nxt;
            ramf_r  <= ramf_nxt;
            trim_r  <= trim_nxt;
        end
    end

    assign step_go             = go_r;
    assign ram_full_range      = ramf_r;
    assign trim_val            = trim_r;
    assign primary_watchdog_en = wdt_r;
    assign fetch_addr          = fetch_r;
    assign vtor                = vtor_r;
    assign branch_addr         = br_r;
    assign user_start          = user_r;
    assign sleep_req           = sleep_r;
    assign error_loop          = err_r;
    assign loader_wait         = lw_r;

    a_rtype_first: assert property (@(posedge clk) disable iff (!rstn)
        (st_r == S_RTYPE) |-> go_r == '0)
        else $error("init step before reset type");
    a_erased_sleeps: assert property (@(posedge clk) disable iff (!rstn)
        (st_r == S_NAC && mode != BMSS_MODE_DEBUG && !vec_ok) |=> sleep_r)
        else $error("erased vector did not sleep");
    a_user_vector: assert property (@(posedge clk) disable iff (!rstn)
        user_r |-> vtor_r == BMSS_ADDR_USER_NVM && br_r != BMSS_VEC_ERASED)
        else $error("bad user entry vector");
    a_nac_zero: assert property (@(posedge clk) disable iff (!rstn)
        (st_r == S_NAC && mode == BMSS_MODE_USER_LOADER && vec_ok && nac_ok &&
         cfg.nac == BMSS_NAC_ZERO) |=> ##1 user_r)
        else $error("zero count did not enter user mode");
    a_invalid_waits: assert property (@(posedge clk) disable iff (!rstn)
        (st_r == S_LOADER && !nac_ok && !loader_done) |=> st_r == S_LOADER)
        else $error("loader wait timed out");
    a_dbg_wdt_off: assert property (@(posedge clk) disable iff (!rstn)
        (mode == BMSS_MODE_DEBUG && st_r == S_DBG) |-> !wdt_r)
        else $error("watchdog on in debug");
    a_ram_order: assert property (@(posedge clk) disable iff (!rstn)
        (st_r == S_RAMT && busy_r && step_done && !init_fail) |=> st_r == S_RAMC)
        else $error("ram clear not after test");
    a_map_linear: assert property (@(posedge clk) disable iff (!rstn)
        go_r.map_init |-> cfg.data_linear)
        else $error("map init outside linear mode");
    a_dbg_sync: assert property (@(posedge clk) disable iff (!rstn)
        (st_r == S_DBG && !dbg_synced) |=> !user_r && st_r == S_DBG)
        else $error("debug start before sync");

endmodule
`default_nettype wire

/* tb/bmss_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bmss_far_model
    import bmss_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Step requests
    input  wire bmss_step_s step_go,
    input  wire logic       hot,
    input  wire logic [3:0] lat,
    input  wire logic       fail_next,
    // Answers
    output logic            step_done,
    output logic            init_fail
);
    logic [4:0] cnt_r;
    logic       busy_r;
    logic       again_r;

    // Hot pll request is an all-zero pulse, so answer it after the trim step
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= 5'h00;
            busy_r <= 1'b0;
            again_r <= 1'b0;
            step_done <= 1'b0;
            init_fail <= 1'b0;
        end else begin
            step_done <= 1'b0;
            init_fail <= 1'b0;
            if (step_go != 6'h00) begin
                busy_r <= 1'b1;
                cnt_r <= {1'b0, lat};
                again_r <= hot && step_go.trim_load;
            end else if (busy_r && cnt_r != 5'h00) begin
                cnt_r <= cnt_r - 5'h01;
            end else if (busy_r) begin
                step_done <= 1'b1;
                init_fail <= fail_next;
                busy_r <= again_r;
                cnt_r <= {1'b0, lat} + 5'h04;
                again_r <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
    import bmss_pkg::*;
;
    logic clk = 1'b0, rstn, dpin, cpin, cfg_valid, loader_active;
    logic loader_done, dbg_synced, hot, fail_next;
    logic [3:0] lat;
    bmss_rst_e rst_type;
    bmss_cfg_s cfg;
    logic [31:0] reset_vec, exp_branch, vtor, branch_addr, fetch_addr;
    bmss_step_s step_go;
    logic step_done, init_fail, ram_full_range, primary_watchdog_en, user_start;
    logic sleep_req, error_loop, loader_wait, sl_d, er_d, lw_d, exp_full;
    logic [15:0] trim_val, lf = 16'h004a;
    logic [7:0] q[$];
    int mismatches = 0, tests_run = 0;

    always #5 clk = ~clk;

    bmss_top #(.NAC_STEP_CYC(4)) i_bmss_top (
        .clk(clk), .rstn(rstn), .mode_data_pin(dpin), .mode_clock_pin(cpin),
        .rst_type(rst_type), .cfg_valid(cfg_valid), .cfg(cfg), .reset_vec(reset_vec),
        .init_fail(init_fail), .step_go(step_go), .step_done(step_done),
        .ram_full_range(ram_full_range), .trim_val(trim_val), .loader_active(loader_active),
        .loader_done(loader_done), .dbg_synced(dbg_synced),
        .primary_watchdog_en(primary_watchdog_en), .fetch_addr(fetch_addr), .vtor(vtor),
        .branch_addr(branch_addr), .user_start(user_start), .sleep_req(sleep_req),
        .error_loop(error_loop), .loader_wait(loader_wait));

    bmss_far_model i_bmss_far_model (
        .clk(clk), .rstn(rstn), .step_go(step_go), .hot(hot), .lat(lat),
        .fail_next(fail_next), .step_done(step_done), .init_fail(init_fail));

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic note(input logic [7:0] code);
        logic [7:0] e;
        if (q.size() == 0) begin
            check({24'h0, code}, 32'h0000_00ee);
        end else begin
            e = q.pop_front();
            check({24'h0, code}, {24'h0, e});
            if (code == 8'h40) begin
                check(branch_addr, exp_branch);
                check(vtor, BMSS_ADDR_USER_NVM);
            end
        end
    endtask

    // Results are read mid-cycle, clear of the edge that launched them
    always @(negedge clk) begin
        if (rstn) begin
            if (step_go != 6'h00) note({2'b00, step_go});
            if (step_go.ram_test || step_go.ram_clear) check(ram_full_range, exp_full);
            if (step_go.trim_load) check(trim_val, cfg.trim);
            if (user_start) note(8'h40);
            if (sleep_req && !sl_d) note(8'h80);
            if (error_loop && !er_d) note(8'hc0);
            if (loader_wait && !lw_d) note(8'h41);
        end
        sl_d = sleep_req;
        er_d = error_loop;
        lw_d = loader_wait;
    end

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic run(input logic dp, input logic cp, input bmss_rst_e rt, input logic [7:0] nac,
                       input logic lin, input logic erased, input logic ecc, input logic full,
                       input logic fail, input logic act);
        logic dbg, res, kick, exp_wdt;
        int i;
        dbg = dp & cp;
        res = dp & !cp;
        kick = act || dbg ||
               (!erased && (ecc || !(nac == 8'h00 || (nac >= 8'h02 && nac <= 8'h1c))));
        exp_wdt = !dbg;
        q.delete();
        lf = lfsr_next(lf);
        exp_branch = {lf, 16'h0000};
        lf = lfsr_next(lf);
        exp_branch[15:0] = {lf[15:1], 1'b0};
        lf = lfsr_next(lf);
        if (res || fail) begin
            q.push_back(fail ? 8'h10 : 8'hc0);
            if (fail) q.push_back(8'hc0);
            exp_wdt = 1'b1;
        end else begin
            if (dbg) q.push_back(8'h20);
            if (rt != BMSS_RST_HOT) begin
                q.push_back(8'h10);
                q.push_back(8'h08);
                if (lin) q.push_back(8'h04);
            end
            q.push_back(8'h02);
            if (rt != BMSS_RST_HOT) q.push_back(8'h01);
            if (!dbg && erased) q.push_back(8'h80);
            if (!dbg && !erased && (ecc || nac != 8'h00)) q.push_back(8'h41);
            if (dbg || !erased) q.push_back(8'h40);
        end
        @(posedge clk);
        rstn <= 1'b0;
        cfg_valid <= 1'b0;
        rst_type <= BMSS_RST_NONE;
        dbg_synced <= 1'b0;
        loader_done <= 1'b0;
        loader_active <= 1'b0;
        dpin <= dp;
        cpin <= cp;
        hot <= (rt == BMSS_RST_HOT);
        lat <= lf[3:0];
        fail_next <= fail;
        exp_full = full;
        cfg <= '{ram_mode_full: full, data_linear: lin, nac: nac, nac_ecc_err: ecc,
                 trim: lfsr_next(lf)};
        reset_vec <= erased ? BMSS_VEC_ERASED : exp_branch;
        repeat (2) @(posedge clk);
        check(fetch_addr, BMSS_ADDR_STARTUP);
        rstn <= 1'b1;
        @(posedge clk);
        rst_type <= rt;
        cfg_valid <= 1'b1;
        repeat (3) @(posedge clk);
        dpin <= ~dp;
        cpin <= ~cp;
        for (i = 0; i < 3000 && q.size() != 0; i++) begin
            @(posedge clk);
            if (kick && q.size() == 1) begin
                // Link activity must freeze the timed window
                if (act) loader_active <= 1'b1;
                repeat (40) @(posedge clk);
                check(32'(q.size()), 32'h1);
                if (dbg) dbg_synced <= 1'b1;
                else loader_done <= 1'b1;
                @(posedge clk);
                loader_done <= 1'b0;
                loader_active <= 1'b0;
                kick = 1'b0;
            end
        end
        if (q.size() != 0) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, q.size(), 0);
        end
        repeat (3) @(posedge clk);
        check(primary_watchdog_en, exp_wdt);
        if (!res) check(fetch_addr, BMSS_ADDR_RESET_VEC);
    endtask

    initial begin
        rstn <= 1'b0;
        repeat (12) @(posedge clk);
        run(0, 0, BMSS_RST_COLD, 8'h00, 0, 0, 0, 1, 0, 0);
        run(0, 1, BMSS_RST_COLD, 8'h02, 1, 0, 0, 0, 0, 0);
        run(0, 1, BMSS_RST_COLD, 8'h1c, 0, 1, 0, 1, 0, 0);
        run(0, 0, BMSS_RST_COLD, 8'h01, 0, 0, 0, 0, 0, 0);
        run(0, 0, BMSS_RST_COLD, 8'hff, 1, 0, 0, 1, 0, 0);
        run(0, 0, BMSS_RST_COLD, 8'h05, 0, 0, 1, 0, 0, 0);
        run(0, 0, BMSS_RST_HOT, 8'h00, 1, 0, 0, 1, 0, 0);
        run(1, 1, BMSS_RST_COLD, 8'h00, 1, 0, 0, 0, 0, 0);
        run(1, 0, BMSS_RST_COLD, 8'h00, 0, 0, 0, 0, 0, 0);
        run(0, 0, BMSS_RST_COLD, 8'h00, 0, 0, 0, 1, 1, 0);
        run(0, 0, BMSS_RST_WARM, 8'h02, 0, 0, 0, 0, 0, 1);
        summarize();
    end
endmodule
`default_nettype wire
